// >>> hdl/rstint_top.sv
// Reset sequencing, stabilization counter and interrupt arbitration
`timescale 1ns/1ps
`include "rstint_defines.svh"

module rstint_top
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic rst_pin_n_i,
   output logic rst_pin_o,
   output logic rst_pin_oe_n_o,
   input wire logic low_voltage_detector_i,
   input wire logic illegal_opcode_i,
   input wire logic stop_exec_i,
   input wire logic unmapped_addr_i,
   input wire logic opcode_fetch_i,
   input wire logic monitor_entry_reset_i,
   input wire logic watchdog_timeout_i,
   input wire logic wake_i,
   input wire logic monitor_mode_i,
   input wire logic break_state_i,
   input wire logic rst_pin_vtst_i,
   input wire logic irq_pin_vtst_i,
   output logic watchdog_disable_o,
   output logic watchdog_tick_o,
   output logic cpu_reset_o,
   output logic bus_clk_en_o,
   input wire logic [15:0] int_req_i,
   input wire logic [15:0] int_en_i,
   input wire logic ibit_i,
   input wire logic instr_done_i,
   input wire logic software_interrupt_instruction_i,
   input wire logic int_serviced_i,
   output rstint_pkg::rstint_stack_t stack_o
);

   rstint_pkg::rstint_state_t s_reg;
   rstint_pkg::rstint_state_t s_next;
   logic [15:0] req_live;
   logic [15:0] req_ok;
   logic illegal_opcode_flag_ev;
   logic illegal_address_flag_ev;
   logic lvi_ev;
   logic int_ev;
   logic rd_hit;
   logic wr_hit;
   logic [7:0] ofs;
   logic ext_rst;

   // Highest priority is the lowest flag number
   function automatic logic [4:0] rstint_pick(input logic [15:0] r);
      logic [4:0] c;
      c = 5'h00;
      for (int i = `RI_NSRC - 1; i >= 0; i--)
      begin
         if (r[i])
         begin
            c = 5'(i + 1);
         end
      end
      return c;
   endfunction : rstint_pick

   // Pure gating, so a noise glitch cannot latch the watchdog off
   assign watchdog_disable_o = (monitor_mode_i &
      (rst_pin_vtst_i | irq_pin_vtst_i)) |
      (break_state_i & rst_pin_vtst_i);

   always_comb
   begin
      req_live = int_req_i;
      req_live[`RI_RSVD_SRC] = 1'b0;
      req_ok = req_live & int_en_i;
      illegal_opcode_flag_ev = illegal_opcode_i |
         (stop_exec_i & ~s_reg.stop_permit);
      illegal_address_flag_ev = unmapped_addr_i & opcode_fetch_i;
      lvi_ev = s_reg.lvi_s[1];
      int_ev = illegal_opcode_flag_ev | illegal_address_flag_ev | lvi_ev | monitor_entry_reset_i |
         watchdog_timeout_i;
      ofs = adr_i[7:0];
      rd_hit = cyc_i & stb_i & ~we_i & ~s_reg.ack;
      // Write lands at the edge where the master sees ack
      wr_hit = cyc_i & stb_i & we_i & s_reg.ack;
      // Own drive of the pin must not look like an external reset
      ext_rst = ~s_reg.pin_s[1] & (s_reg.st == rstint_pkg::RS_RUN);
   end

   always_comb
   begin
      s_next = s_reg;
      s_next.lvi_s = {s_reg.lvi_s[0], low_voltage_detector_i};
      s_next.pin_s = {s_reg.pin_s[0], rst_pin_n_i};
      s_next.ibit_d = ibit_i;
      s_next.stk.take = 1'b0;
      s_next.stk.push_regs = 1'b0;
      s_next.stk.set_mask = 1'b0;
      s_next.stk.push_hix = 1'b0;
      s_next.wd_tick = 1'b0;
      s_next.ack = cyc_i & stb_i & ~s_reg.ack;
      s_next.dat = 32'h0000_0000;
      if (rd_hit && ofs == `RI_OFS_CAUSE)
      begin
         s_next.cause = '0;
      end

      // Single clock, so the count steps on the rising edge
      // Counter: runs in every state but stop, untouched by external reset
      if (s_reg.st != rstint_pkg::RS_STOP)
      begin
         s_next.cnt = s_reg.cnt + 13'h0001;
         if (&s_reg.cnt)
         begin
            s_next.wd_tick = 1'b1;
         end
      end

      unique case (s_reg.st)
         rstint_pkg::RS_RUN:
         begin
            if (stop_exec_i && s_reg.stop_permit)
            begin
               s_next.st = rstint_pkg::RS_STOP;
               s_next.cnt = '0;
            end
         end
         rstint_pkg::RS_DRIVE:
         begin
            if ((s_reg.long_seq &&
               s_reg.cnt == 13'(`RI_POR_CYC - 1)) ||
               (!s_reg.long_seq &&
               s_reg.cnt == 13'(`RI_ACTIVE_CYC - 1)))
            begin
               s_next.st = rstint_pkg::RS_HOLD;
            end
         end
         rstint_pkg::RS_HOLD:
         begin
            if ((s_reg.long_seq &&
               s_reg.cnt == 13'(`RI_POR_CYC + `RI_POR_HOLD - 1)) ||
               (!s_reg.long_seq &&
               s_reg.cnt == 13'(`RI_ACTIVE_CYC + `RI_ACTIVE_HOLD - 1)))
            begin
               s_next.st = rstint_pkg::RS_RUN;
            end
         end
         rstint_pkg::RS_STOP:
         begin
            if (wake_i)
            begin
               s_next.st = rstint_pkg::RS_RECOVER;
               s_next.short_rec = s_reg.stop_permit &
                  s_reg.short_rec;
               s_next.cnt = '0;
            end
         end
         rstint_pkg::RS_RECOVER:
         begin
            if ((s_reg.short_rec &&
               s_reg.cnt == 13'(`RI_SHORT_REC - 1)) ||
               (!s_reg.short_rec &&
               s_reg.cnt == 13'(`RI_LONG_REC - 1)))
            begin
               s_next.st = rstint_pkg::RS_RUN;
            end
         end
      endcase

      // Internal reset restarts the sequence, except mid-sequence
      if (int_ev && s_reg.st != rstint_pkg::RS_DRIVE &&
         s_reg.st != rstint_pkg::RS_HOLD)
      begin
         s_next.st = rstint_pkg::RS_DRIVE;
         s_next.cnt = '0;
         s_next.long_seq = lvi_ev;
         s_next.lat_v = 1'b0;
         s_next.stop_permit = `RI_CTL_RST;
         s_next.short_rec = `RI_CTL_RST;
      end

      // Cause bits: a set in the clearing read cycle wins
      if (illegal_opcode_flag_ev)
      begin
         s_next.cause.illegal_opcode_flag = 1'b1;
      end
      if (illegal_address_flag_ev)
      begin
         s_next.cause.illegal_address_flag = 1'b1;
      end
      if (lvi_ev)
      begin
         s_next.cause.low_voltage_detector = 1'b1;
      end
      if (monitor_entry_reset_i)
      begin
         s_next.cause.monitor_entry_reset = 1'b1;
      end
      if (watchdog_timeout_i)
      begin
         s_next.cause.wdog = 1'b1;
      end
      if (ext_rst)
      begin
         s_next.cause.pin = 1'b1;
      end

      // Interrupt latch and arbitration
      if (s_reg.lat_v && (int_serviced_i ||
         (s_reg.ibit_d && !ibit_i && s_reg.stk.vec != `RI_VEC_SWI)))
      begin
         s_next.lat_v = 1'b0;
      end
      else if (!s_reg.lat_v && instr_done_i &&
         s_reg.st == rstint_pkg::RS_RUN && !int_ev && !ext_rst)
      begin
         if (software_interrupt_instruction_i)
         begin
            s_next.lat_v = 1'b1;
            s_next.stk.take = 1'b1;
            s_next.stk.vec = `RI_VEC_SWI;
            s_next.stk.push_pc_dec = 1'b0;
            s_next.stk.push_regs = 1'b1;
            s_next.stk.set_mask = 1'b1;
         end
         else if (!ibit_i && |req_ok)
         begin
            s_next.lat_v = 1'b1;
            s_next.stk.take = 1'b1;
            s_next.stk.vec = rstint_pick(req_ok);
            s_next.stk.push_pc_dec = 1'b1;
            s_next.stk.push_regs = 1'b1;
            s_next.stk.set_mask = 1'b1;
         end
      end

      // Register bus
      if (wr_hit && ofs == `RI_OFS_CTRL && sel_i[0])
      begin
         s_next.stop_permit = dat_i[`RI_CTL_STOP];
         s_next.short_rec = dat_i[`RI_CTL_SSR];
      end
      if (rd_hit)
      begin
         unique case (ofs)
            `RI_OFS_CAUSE: s_next.dat = 32'(s_reg.cause);
            `RI_OFS_INTST: s_next.dat = 32'(req_live);
            `RI_OFS_CTRL: s_next.dat = 32'({s_reg.short_rec,
               s_reg.stop_permit});
            `RI_OFS_CNT: s_next.dat = 32'(s_reg.cnt);
            default: s_next.dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         // Power-on: long sequence with only the power cause set
         s_reg <= '0;
         s_reg.st <= rstint_pkg::RS_DRIVE;
         s_reg.long_seq <= 1'b1;
         s_reg.cause.por <= 1'b1;
         s_reg.lvi_s <= 2'h0;
         s_reg.pin_s <= 2'h3;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign dat_o = s_reg.dat;
   assign ack_o = s_reg.ack;
   assign rst_pin_o = 1'b0;
   assign rst_pin_oe_n_o = (s_reg.st != rstint_pkg::RS_DRIVE);
   assign cpu_reset_o = (s_reg.st == rstint_pkg::RS_DRIVE) ||
      (s_reg.st == rstint_pkg::RS_HOLD) || ext_rst;
   assign bus_clk_en_o = (s_reg.st == rstint_pkg::RS_RUN);
   assign watchdog_tick_o = s_reg.wd_tick;
   assign stack_o = s_reg.stk;

   default clocking ck @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence seq_short_drive;
      (s_reg.st == rstint_pkg::RS_DRIVE && !s_reg.long_seq &&
         s_reg.cnt == 13'h0000);
   endsequence
   sequence seq_hold_end;
      ##32 (s_reg.st == rstint_pkg::RS_HOLD) ##32
         (s_reg.st == rstint_pkg::RS_RUN);
   endsequence

   AST_SHORT_SEQ: assert property (
      seq_short_drive |-> seq_hold_end)
      else $error("Short reset sequence length wrong");
   AST_PIN_LOW: assert property (
      $rose(s_reg.st == rstint_pkg::RS_DRIVE) |->
         !rst_pin_oe_n_o && cpu_reset_o)
      else $error("Reset pin not driven in drive phase");
   AST_ILLEGAL_OPCODE_FLAG: assert property (
      illegal_opcode_i |=> s_reg.cause.illegal_opcode_flag &&
         s_reg.st == rstint_pkg::RS_DRIVE || $past(s_reg.st) ==
         rstint_pkg::RS_DRIVE || $past(s_reg.st) ==
         rstint_pkg::RS_HOLD)
      else $error("Illegal opcode not recorded");
   AST_DATA_FETCH: assert property (
      unmapped_addr_i && !opcode_fetch_i && !illegal_opcode_i &&
         !stop_exec_i && !low_voltage_detector_i &&
         !monitor_entry_reset_i && !watchdog_timeout_i &&
         !s_reg.lvi_s[1] && !s_reg.lvi_s[0] &&
         s_reg.st == rstint_pkg::RS_RUN |=> !s_reg.cause.illegal_address_flag ||
         $past(s_reg.cause.illegal_address_flag))
      else $error("Data fetch caused illegal address");
   AST_STOP_CLR: assert property (
      s_reg.st == rstint_pkg::RS_STOP |-> s_reg.cnt == 13'h0000)
      else $error("Counter not cleared in stop");
   AST_WD_TICK: assert property (
      watchdog_tick_o |-> $past(s_reg.cnt) == 13'h1FFF)
      else $error("Watchdog tick without overflow");
   AST_WD_DIS: assert property (
      monitor_mode_i && irq_pin_vtst_i |-> watchdog_disable_o)
      else $error("Watchdog not disabled");
   AST_MASK: assert property (
      instr_done_i && ibit_i && !software_interrupt_instruction_i
         && !s_reg.lat_v |=> !stack_o.take)
      else $error("Masked interrupt taken");
   AST_HOLD_VEC: assert property (
      s_reg.lat_v && !int_serviced_i && ibit_i |=>
         $stable(stack_o.vec))
      else $error("Latched vector displaced");
   AST_NO_HIX: assert property (
      stack_o.take |-> !stack_o.push_hix && stack_o.set_mask)
      else $error("High index stacked");
   AST_TAKE_RUN: assert property (
      stack_o.take |-> $past(bus_clk_en_o))
      else $error("Interrupt taken outside run state");

endmodule : rstint_top

// >>> include/rstint_defines.svh
// Constants of the reset and interrupt sequencer
`ifndef RSTINT_DEFINES_SVH
`define RSTINT_DEFINES_SVH
`define RI_CNT_W 13
`define RI_ACTIVE_CYC 32
`define RI_ACTIVE_HOLD 32
`define RI_POR_CYC 4096
`define RI_POR_HOLD 64
`define RI_SHORT_REC 32
`define RI_LONG_REC 4096
`define RI_NSRC 16
`define RI_RSVD_SRC 6
`define RI_OFS_CAUSE 8'h00
`define RI_OFS_INTST 8'h04
`define RI_OFS_CTRL 8'h08
`define RI_OFS_CNT 8'h0C
`define RI_CTL_STOP 0
`define RI_CTL_SSR 1
`define RI_CTL_RST 1'h0
`define RI_VEC_SWI 5'h00
`endif

// >>> include/rstint_pkg.sv
// Types of the reset and interrupt sequencer
package rstint_pkg;
   typedef enum logic [2:0]
   {
      RS_RUN = 3'h0,
      RS_DRIVE = 3'h1,
      RS_HOLD = 3'h3,
      RS_STOP = 3'h2,
      RS_RECOVER = 3'h6
   } rstint_rst_st_t;
   typedef struct packed {
      logic low_voltage_detector;
      logic monitor_entry_reset;
      logic illegal_address_flag;
      logic illegal_opcode_flag;
      logic wdog;
      logic pin;
      logic por;
   } rstint_cause_t;
   typedef struct packed {
      logic take;
      logic push_regs;
      logic push_pc_dec;
      logic push_hix;
      logic set_mask;
      logic [4:0] vec;
   } rstint_stack_t;
   typedef struct packed {
      rstint_rst_st_t st;
      logic [12:0] cnt;
      logic long_seq;
      logic short_rec;
      logic stop_permit;
      rstint_cause_t cause;
      logic [1:0] lvi_s;
      logic [1:0] pin_s;
      logic wd_tick;
      logic lat_v;
      logic ibit_d;
      rstint_stack_t stk;
      logic ack;
      logic [31:0] dat;
   } rstint_state_t;
endpackage : rstint_pkg

// >>> sim/rstint_cpu_model.sv
// Behavioural CPU core on the far side of the sequencer
`timescale 1ns/1ps
module rstint_cpu_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic mask_i,
   input wire logic [3:0] svc_len_i,
   input wire rstint_pkg::rstint_stack_t stack_i,
   output logic instr_done_o,
   output logic int_serviced_o,
   output logic ibit_o
);
   logic busy;
   logic [3:0] cnt;
   // Mask follows the routine, so a slow routine blocks longer
   assign ibit_o = busy | mask_i;
   always_ff @(posedge clk_i)
   begin
      int_serviced_o <= 1'b0;
      // One instruction ends every other cycle, never mid-instruction
      instr_done_o <= run_i & ~instr_done_o;
      if (rst_i || !run_i)
      begin
         busy <= 1'b0;
         cnt <= 4'h0;
      end
      else if (stack_i.take && stack_i.set_mask)
      begin
         busy <= 1'b1;
         cnt <= svc_len_i;
      end
      else if (busy && cnt == 4'h0)
      begin
         busy <= 1'b0;
         int_serviced_o <= 1'b1;
      end
      else if (busy)
         cnt <= cnt - 4'h1;
   end
endmodule : rstint_cpu_model

// >>> sim/rstint_top_tb.sv
// Self-checking bench of the reset and interrupt sequencer
`timescale 1ns/1ps
module rstint_top_tb;
   logic clk_i, rst_i, cyc, stb, we, ack, oe_n, cpu_rst, bus_en, wd_dis;
   logic pin_n, lowv, illop, stopx, unmap, opf, modr, wdt, wake;
   logic mon, brk, rvt, ivt, ibit, idone, sw_int, serv, mask, pin_o, wtick;
   logic [31:0] adr, dat, dout, q, c0;
   logic [31:0] cz[5] = '{32'h08, 32'h08, 32'h10, 32'h20, 32'h04};
   logic [15:0] req, en;
   logic [3:0] svc;
   rstint_pkg::rstint_stack_t stk;
   logic [4:0] vq[$];
   int n_mismatch, checked, cycles, n;
   // Open-drain reset pin: low while driven, else the bench level
   rstint_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
      .dat_o(dout), .ack_o(ack), .rst_pin_n_i(oe_n ? pin_n : pin_o),
      .rst_pin_o(pin_o),
      .rst_pin_oe_n_o(oe_n), .low_voltage_detector_i(lowv),
      .illegal_opcode_i(illop), .stop_exec_i(stopx),
      .unmapped_addr_i(unmap), .opcode_fetch_i(opf),
      .monitor_entry_reset_i(modr), .watchdog_timeout_i(wdt),
      .wake_i(wake), .monitor_mode_i(mon), .break_state_i(brk),
      .rst_pin_vtst_i(rvt), .irq_pin_vtst_i(ivt),
      .watchdog_disable_o(wd_dis), .watchdog_tick_o(wtick),
      .cpu_reset_o(cpu_rst), .bus_clk_en_o(bus_en), .int_req_i(req),
      .int_en_i(en), .ibit_i(ibit), .instr_done_i(idone),
      .software_interrupt_instruction_i(sw_int),
      .int_serviced_i(serv), .stack_o(stk));
   rstint_cpu_model cpu_u (.clk_i(clk_i), .rst_i(rst_i),
      .run_i(bus_en & ~cpu_rst), .mask_i(mask), .svc_len_i(svc),
      .stack_i(stk), .instr_done_o(idone), .int_serviced_o(serv),
      .ibit_o(ibit));
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e,
      input string m);
      checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {24'h000000, a};
      dat <= d;
      // Request held until ack is seen; only the bench timeout ends it
      do
      begin
         @(posedge clk_i);
      end
      while (ack !== 1'b1);
      r = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   // Measures pin drive length and the extra internal reset hold
   task automatic seq(input int dr, input int hd);
      int a, h;
      a = 0;
      h = 0;
      while (oe_n !== 1'b0 && a < 10)
      begin
         @(posedge clk_i);
         a++;
      end
      a = 0;
      while (oe_n === 1'b0 && a < 5000)
      begin
         @(posedge clk_i);
         a++;
      end
      while (cpu_rst === 1'b1 && h < 100)
      begin
         @(posedge clk_i);
         h++;
      end
      chk(a, dr, "pin drive length");
      chk(h, hd, "reset hold length");
   endtask : seq
   task automatic fire(input int k);
      case (k)
         0: illop <= 1'b1;
         1: stopx <= 1'b1;
         2: {unmap, opf} <= 2'h3;
         3: modr <= 1'b1;
         default: wdt <= 1'b1;
      endcase
      @(posedge clk_i);
      {illop, stopx, unmap, opf, modr, wdt} <= 6'h00;
   endtask : fire
   task results;
      if (n_mismatch == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results
   // Source is cleared by its routine as soon as it is taken
   always @(posedge clk_i)
   begin
      if (stk.take === 1'b1)
      begin
         vq.push_back(stk.vec);
         chk({28'h0, stk.push_regs, stk.set_mask, stk.push_hix,
            stk.push_pc_dec}, {28'h0, 3'h6, stk.vec != 5'h00}, "stack");
         if (stk.vec != 5'h00)
            req[stk.vec - 5'h01] <= 1'b0;
      end
   end
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         n_mismatch++;
         results();
      end
   end
   initial
   begin
      {rst_i, pin_n, mask} = 3'h7;
      {cyc, stb, we, lowv, illop, stopx, unmap, opf, modr, wdt} = 10'h000;
      {wake, mon, brk, rvt, ivt, sw_int} = 6'h00;
      {adr, dat, req, en, svc} = {64'h0, 16'h0, 16'hFFFF, 4'h3};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      seq(4096, 64);
      wb(1'b0, 8'h00, 32'h0, q);
      chk(q, 32'h01, "power-on cause");
      for (int i = 0; i < 16; i++)
      begin
         {mon, brk, rvt, ivt} <= i[3:0];
         @(posedge clk_i);
         chk({31'h0, wd_dis}, {31'h0, mon & (rvt | ivt) | brk & rvt},
            "watchdog gate");
      end
      @(posedge clk_i);
      {mon, brk, rvt, ivt} <= 4'h0;
      for (int k = 0; k < 5; k++)
      begin
         fire(k);
         seq(32, 32);
         wb(1'b0, 8'h0C, 32'h0, q);
         chk({31'h0, q < 32'h80}, 32'h1, "counter cleared");
         wb(1'b0, 8'h00, 32'h0, q);
         chk(q, cz[k], "cause");
      end
      unmap <= 1'b1;
      @(posedge clk_i);
      unmap <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk({31'h0, oe_n}, 32'h1, "data fetch reset");
      wb(1'b0, 8'h0C, 32'h0, c0);
      pin_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      pin_n <= 1'b1;
      repeat (6) @(posedge clk_i);
      wb(1'b0, 8'h0C, 32'h0, q);
      chk({31'h0, q > c0}, 32'h1, "pin reset counter");
      wb(1'b0, 8'h00, 32'h0, q);
      chk(q, 32'h02, "pin cause");
      lowv <= 1'b1;
      repeat (3) @(posedge clk_i);
      lowv <= 1'b0;
      seq(4096, 64);
      wb(1'b0, 8'h00, 32'h0, q);
      chk(q, 32'h40, "low voltage cause");
      for (int s = 0; s < 2; s++)
      begin
         wb(1'b1, 8'h08, s ? 32'h1 : 32'h3, q);
         fire(1);
         repeat (4) @(posedge clk_i);
         wb(1'b0, 8'h0C, 32'h0, q);
         chk(q, 32'h0, "stop clears counter");
         wake <= 1'b1;
         @(posedge clk_i);
         wake <= 1'b0;
         n = 0;
         while (bus_en !== 1'b1 && n < 5000)
         begin
            @(posedge clk_i);
            n++;
         end
         c0 = s ? 32'd4096 : 32'd32;
         chk({31'h0, n >= c0 && n <= c0 + 2}, 32'h1, "recovery");
      end
      req <= 16'h0007;
      en <= 16'hFFFD;
      wb(1'b1, 8'h04, 32'hFFFF, q);
      wb(1'b0, 8'h04, 32'h0, q);
      chk(q, 32'h07, "status");
      req <= 16'h0047;
      mask <= 1'b0;
      repeat (80) @(posedge clk_i);
      chk(vq.size(), 2, "take count");
      mask <= 1'b1;
      svc <= 4'hC;
      sw_int <= 1'b1;
      n = 0;
      while (vq.size() < 3 && n < 100)
      begin
         @(posedge clk_i);
         n++;
      end
      sw_int <= 1'b0;
      req[0] <= 1'b1;
      repeat (40) @(posedge clk_i);
      chk(vq.size(), 3, "masked");
      mask <= 1'b0;
      repeat (40) @(posedge clk_i);
      chk(vq.size(), 4, "unmasked");
      if (vq.size() == 4)
         chk({vq[0], vq[1], vq[2], vq[3]}, {5'h01, 5'h03, 5'h00, 5'h01},
            "vectors");
      // Tick follows the all-ones count, so the counter has just wrapped
      n = 0;
      while (wtick !== 1'b1 && n < 8200)
      begin
         @(posedge clk_i);
         n++;
      end
      wb(1'b0, 8'h0C, 32'h0, q);
      chk(q, 32'h1, "counter wrap tick");
      results();
   end
endmodule : rstint_top_tb
